// *** src/pd_vbus_regs_pkg.sv ***
/*
  Package for the port-controller power register bank: register offsets, reset values,
  field widths, code limits and the packed carriers shared by the bank and its users.
  Assumes a byte-wide register port with printed offsets used as the addresses.
*/
`default_nettype none

package pd_vbus_regs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] TX_PAYLOAD_PORT_OFS     = 8'h51;
  localparam logic [7:0] VOLT_MEAS_LOW_OFS       = 8'h70;
  localparam logic [7:0] VOLT_MEAS_HIGH_OFS      = 8'h71;
  localparam logic [7:0] DISCH_STOP_LOW_OFS      = 8'h74;
  localparam logic [7:0] DISCH_STOP_HIGH_OFS     = 8'h75;
  localparam logic [7:0] OVER_TRIP_LOW_OFS       = 8'h76;
  localparam logic [7:0] OVER_TRIP_HIGH_OFS      = 8'h77;
  localparam logic [7:0] UNDER_TRIP_LOW_OFS      = 8'h78;
  localparam logic [7:0] UNDER_TRIP_HIGH_OFS     = 8'h79;
  localparam logic [7:0] TARGET_LOW_OFS          = 8'h7A;
  localparam logic [7:0] TARGET_HIGH_OFS         = 8'h7B;
  localparam logic [7:0] LOAD_CURR_MEAS_OFS      = 8'h80;
  localparam logic [7:0] CABLE_DROP_GAIN_OFS     = 8'h81;
  localparam logic [7:0] CURR_LIMIT_TARGET_OFS   = 8'h82;
  localparam logic [7:0] CONVERTER_SETUP_OFS     = 8'h83;
  localparam logic [7:0] SUPERVISOR_TIMEOUT_OFS  = 8'h84;

  // ****************************************************************
  // Widths, reset values and code limits
  // ****************************************************************
  localparam int unsigned TX_BUF_DEPTH           = 30;
  localparam int unsigned VOLT_W                 = 10;
  localparam int unsigned CURR_W                 = 7;
  localparam int unsigned GAIN_W                 = 6;
  localparam int unsigned TARGET_W               = 16;
  localparam int unsigned TARGET_FINE_W          = 11;
  localparam int unsigned TARGET_COARSE_W        = 10;
  localparam logic [9:0]  DISCH_STOP_RST         = 10'h020;
  localparam logic [9:0]  DISCH_FLOOR_MAX        = 10'h018;
  localparam logic [9:0]  DISCH_FLOOR_LEVEL      = 10'h014;
  localparam logic [9:0]  DISCH_IGNORE_MASK      = 10'h3FC;
  localparam logic [7:0]  CURR_LIMIT_RST         = 8'h80;
  localparam logic [7:0]  CONVERTER_SETUP_RST    = 8'h74;
  localparam logic [1:0]  SUPERVISOR_TIMEOUT_RST = 2'h0;
  localparam logic [10:0] COARSE_TARGET_MIN      = 11'h0A5;
  localparam logic [10:0] COARSE_TARGET_MAX      = 11'h3FF;
  localparam logic [10:0] FINE_TARGET_MIN        = 11'h14A;
  localparam logic [10:0] FINE_TARGET_MAX        = 11'h7FF;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] ramp_peak_sel;
    logic [1:0] switch_freq_sel;
    logic       sync_dir_in;
    logic [1:0] spread_sel;
  } converter_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] code;
  } volt_sample_t;

  typedef enum logic [1:0] {
    TXB_AWAIT_COUNT = 2'b00,
    TXB_TAKING      = 2'b01,
    TXB_FILLED      = 2'b11
  } txb_state_t;

endpackage

`default_nettype wire

// *** src/pd_vbus_regs.sv ***
/*
  Power and transmit-payload register bank of a USB Type-C port controller.
  Assumes a byte-wide register port (address, write strobe, read strobe) decoded by an
  I2C target outside, which pulses xact_start_i at the start of every write transaction.
  ADC results arrive as one-cycle valid pulses; the PHY reports each finished attempt.
*/
`default_nettype none

module pd_vbus_regs #(
  parameter int unsigned TX_DEPTH = pd_vbus_regs_pkg::TX_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                             clk_sys_i,
  input  wire logic                             sys_rst_i,
  // Register port
  input  wire logic [7:0]                       reg_addr_i,
  input  wire logic                             reg_wr_i,
  input  wire logic [7:0]                       reg_wdata_i,
  input  wire logic                             reg_rd_i,
  input  wire logic                             xact_start_i,
  output logic [7:0]                            reg_rdata_o,
  // Transmit path
  input  wire logic                             tx_start_i,
  input  wire logic                             tx_done_i,
  input  wire logic [4:0]                       tx_rd_idx_i,
  output logic                                  tx_req_o,
  output logic [4:0]                            tx_len_o,
  output logic [7:0]                            tx_rd_data_o,
  output logic                                  tx_overflow_o,
  // Measurements
  input  wire pd_vbus_regs_pkg::volt_sample_t   volt_sample_i,
  input  wire logic                             curr_valid_i,
  input  wire logic [6:0]                       curr_code_i,
  // Alarms
  input  wire logic                             volt_alarm_disable_n_i,
  input  wire logic                             over_flag_clr_i,
  input  wire logic                             under_flag_clr_i,
  output logic                                  over_volt_flag_o,
  output logic                                  under_volt_flag_o,
  // Output voltage target
  input  wire logic                             fine_target_step_i,
  input  wire logic                             apply_custom_voltage_cmd_i,
  output logic [10:0]                           target_code_o,
  output logic                                  target_in_range_o,
  // Converter settings
  output logic [9:0]                            discharge_stop_level_o,
  output logic [5:0]                            cable_drop_gain_o,
  output logic [7:0]                            current_limit_target_o,
  output pd_vbus_regs_pkg::converter_cfg_t      converter_cfg_o,
  output logic [1:0]                            supervisor_timeout_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0]                       tx_buf_q [TX_DEPTH];
  logic [4:0]                       tx_ptr_q;
  logic [7:0]                       tx_remain_q;
  logic                             tx_req_q;
  logic                             tx_ovf_q;
  pd_vbus_regs_pkg::txb_state_t     txb_state_q;
  logic [9:0]                       vbus_meas_q;
  logic [6:0]                       curr_meas_q;
  logic [9:0]                       disch_stop_q;
  logic [9:0]                       over_trip_q;
  logic [9:0]                       under_trip_q;
  logic [15:0]                      target_stage_q;
  logic [10:0]                      target_q;
  logic [5:0]                       gain_q;
  logic [7:0]                       ilim_q;
  pd_vbus_regs_pkg::converter_cfg_t conv_q;
  logic [1:0]                       timeout_q;
  logic                             over_cond_q;
  logic                             under_cond_q;
  logic                             over_flag_q;
  logic                             under_flag_q;
  logic [7:0]                       rdata_q;
  logic [10:0]                      stage_code;
  logic                             wr_txport;
  logic                             buf_store;

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = reg_wr_i && (reg_addr_i == ofs);
  endfunction

  // ****************************************************************
  // Transmit payload port
  // ****************************************************************
  assign wr_txport = wr_at(pd_vbus_regs_pkg::TX_PAYLOAD_PORT_OFS);
  // Bytes past the buffer end are dropped and flagged rather than wrapping over the header.
  assign buf_store = wr_txport && (txb_state_q == pd_vbus_regs_pkg::TXB_TAKING)
                     && (tx_ptr_q < 5'(TX_DEPTH)) && !xact_start_i;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || tx_done_i) begin
      txb_state_q <= pd_vbus_regs_pkg::TXB_AWAIT_COUNT;
      tx_remain_q <= 8'h00;
      tx_ptr_q    <= 5'h00;
    end else if (xact_start_i) begin
      txb_state_q <= pd_vbus_regs_pkg::TXB_AWAIT_COUNT;
    end else if (wr_txport) begin
      case (txb_state_q)
        pd_vbus_regs_pkg::TXB_AWAIT_COUNT: begin
          tx_remain_q <= reg_wdata_i;
          txb_state_q <= (reg_wdata_i == 8'h00) ? pd_vbus_regs_pkg::TXB_FILLED : pd_vbus_regs_pkg::TXB_TAKING;
        end
        pd_vbus_regs_pkg::TXB_TAKING: begin
          tx_remain_q <= tx_remain_q - 8'h01;
          if (buf_store) begin
            tx_ptr_q <= tx_ptr_q + 5'h01;
          end
          if (tx_remain_q == 8'h01) begin
            txb_state_q <= pd_vbus_regs_pkg::TXB_FILLED;
          end
        end
        pd_vbus_regs_pkg::TXB_FILLED: begin
          txb_state_q <= pd_vbus_regs_pkg::TXB_FILLED;
        end
        default: begin
          txb_state_q <= pd_vbus_regs_pkg::TXB_AWAIT_COUNT;
        end
      endcase
    end
  end

  for (genvar e = 0; e < TX_DEPTH; e++) begin : g_txbuf
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || tx_done_i) begin
        tx_buf_q[e] <= 8'h00;
      end else if (buf_store && (tx_ptr_q == 5'(e))) begin
        tx_buf_q[e] <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_req_q <= 1'b0;
      tx_ovf_q <= 1'b0;
    end else begin
      // A finished attempt outranks a new request in the same cycle.
      tx_req_q <= tx_done_i ? 1'b0 : (tx_start_i | tx_req_q);
      tx_ovf_q <= tx_done_i ? 1'b0 : (tx_ovf_q | (wr_txport && (txb_state_q == pd_vbus_regs_pkg::TXB_TAKING)
                                                  && !xact_start_i && !buf_store));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_rd_data_o <= 8'h00;
    end else begin
      tx_rd_data_o <= (tx_rd_idx_i < 5'(TX_DEPTH)) ? tx_buf_q[tx_rd_idx_i] : 8'h00;
    end
  end

  // ****************************************************************
  // Measurements and alarms
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      vbus_meas_q  <= 10'h000;
      over_cond_q  <= 1'b0;
      under_cond_q <= 1'b0;
    end else if (volt_sample_i.valid) begin
      vbus_meas_q  <= volt_sample_i.code;
      over_cond_q  <= volt_sample_i.code > over_trip_q;
      under_cond_q <= volt_sample_i.code < under_trip_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      curr_meas_q <= 7'h00;
    end else if (curr_valid_i) begin
      curr_meas_q <= curr_code_i;
    end
  end

  // A standing condition sets the flag in the very cycle it is cleared, so nothing is lost.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      over_flag_q  <= 1'b0;
      under_flag_q <= 1'b0;
    end else begin
      over_flag_q  <= (over_cond_q && !volt_alarm_disable_n_i) ? 1'b1 : (over_flag_q && !over_flag_clr_i);
      under_flag_q <= (under_cond_q && !volt_alarm_disable_n_i) ? 1'b1 : (under_flag_q && !under_flag_clr_i);
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      disch_stop_q <= pd_vbus_regs_pkg::DISCH_STOP_RST;
      over_trip_q  <= 10'h000;
      under_trip_q <= 10'h000;
    end else begin
      if (wr_at(pd_vbus_regs_pkg::DISCH_STOP_LOW_OFS))   disch_stop_q[7:0] <= reg_wdata_i;
      if (wr_at(pd_vbus_regs_pkg::DISCH_STOP_HIGH_OFS))  disch_stop_q[9:8] <= reg_wdata_i[1:0];
      if (wr_at(pd_vbus_regs_pkg::OVER_TRIP_LOW_OFS))    over_trip_q[7:0]  <= reg_wdata_i;
      if (wr_at(pd_vbus_regs_pkg::OVER_TRIP_HIGH_OFS))   over_trip_q[9:8]  <= reg_wdata_i[1:0];
      if (wr_at(pd_vbus_regs_pkg::UNDER_TRIP_LOW_OFS))   under_trip_q[7:0] <= reg_wdata_i;
      if (wr_at(pd_vbus_regs_pkg::UNDER_TRIP_HIGH_OFS))  under_trip_q[9:8] <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gain_q    <= 6'h00;
      ilim_q    <= pd_vbus_regs_pkg::CURR_LIMIT_RST;
      conv_q    <= pd_vbus_regs_pkg::CONVERTER_SETUP_RST;
      timeout_q <= pd_vbus_regs_pkg::SUPERVISOR_TIMEOUT_RST;
    end else begin
      if (wr_at(pd_vbus_regs_pkg::CABLE_DROP_GAIN_OFS))    gain_q    <= reg_wdata_i[5:0];
      if (wr_at(pd_vbus_regs_pkg::CURR_LIMIT_TARGET_OFS))  ilim_q    <= reg_wdata_i;
      if (wr_at(pd_vbus_regs_pkg::CONVERTER_SETUP_OFS))    conv_q    <= reg_wdata_i;
      if (wr_at(pd_vbus_regs_pkg::SUPERVISOR_TIMEOUT_OFS)) timeout_q <= reg_wdata_i[1:0];
    end
  end

  // ****************************************************************
  // Output voltage target
  // ****************************************************************
  // The coarse step keeps ten bits and the fine step eleven; upper staged bits are ignored.
  assign stage_code = fine_target_step_i ? target_stage_q[10:0]
                                         : {1'b0, target_stage_q[9:0]};

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      target_stage_q    <= 16'h0000;
      target_q          <= 11'h000;
      target_in_range_o <= 1'b0;
    end else begin
      if (wr_at(pd_vbus_regs_pkg::TARGET_LOW_OFS))  target_stage_q[7:0]  <= reg_wdata_i;
      if (wr_at(pd_vbus_regs_pkg::TARGET_HIGH_OFS)) target_stage_q[15:8] <= reg_wdata_i;
      if (apply_custom_voltage_cmd_i) begin
        target_q <= stage_code;
        // Out-of-range codes are the host's fault; the bank only reports them.
        target_in_range_o <= fine_target_step_i
          ? (stage_code >= pd_vbus_regs_pkg::FINE_TARGET_MIN && stage_code <= pd_vbus_regs_pkg::FINE_TARGET_MAX)
          : (stage_code >= pd_vbus_regs_pkg::COARSE_TARGET_MIN
             && stage_code <= pd_vbus_regs_pkg::COARSE_TARGET_MAX);
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        pd_vbus_regs_pkg::VOLT_MEAS_LOW_OFS:      rdata_q <= vbus_meas_q[7:0];
        pd_vbus_regs_pkg::VOLT_MEAS_HIGH_OFS:     rdata_q <= {6'h00, vbus_meas_q[9:8]};
        pd_vbus_regs_pkg::DISCH_STOP_LOW_OFS:     rdata_q <= disch_stop_q[7:0];
        pd_vbus_regs_pkg::DISCH_STOP_HIGH_OFS:    rdata_q <= {6'h00, disch_stop_q[9:8]};
        pd_vbus_regs_pkg::OVER_TRIP_LOW_OFS:      rdata_q <= over_trip_q[7:0];
        pd_vbus_regs_pkg::OVER_TRIP_HIGH_OFS:     rdata_q <= {6'h00, over_trip_q[9:8]};
        pd_vbus_regs_pkg::UNDER_TRIP_LOW_OFS:     rdata_q <= under_trip_q[7:0];
        pd_vbus_regs_pkg::UNDER_TRIP_HIGH_OFS:    rdata_q <= {6'h00, under_trip_q[9:8]};
        pd_vbus_regs_pkg::TARGET_LOW_OFS:         rdata_q <= target_stage_q[7:0];
        pd_vbus_regs_pkg::TARGET_HIGH_OFS:        rdata_q <= target_stage_q[15:8];
        pd_vbus_regs_pkg::LOAD_CURR_MEAS_OFS:     rdata_q <= {1'b0, curr_meas_q};
        pd_vbus_regs_pkg::CABLE_DROP_GAIN_OFS:    rdata_q <= {2'h0, gain_q};
        pd_vbus_regs_pkg::CURR_LIMIT_TARGET_OFS:  rdata_q <= ilim_q;
        pd_vbus_regs_pkg::CONVERTER_SETUP_OFS:    rdata_q <= conv_q;
        pd_vbus_regs_pkg::SUPERVISOR_TIMEOUT_OFS: rdata_q <= {6'h00, timeout_q};
        default:                                  rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o            = rdata_q;
  assign tx_req_o               = tx_req_q;
  assign tx_len_o               = tx_ptr_q;
  assign tx_overflow_o          = tx_ovf_q;
  assign over_volt_flag_o       = over_flag_q;
  assign under_volt_flag_o      = under_flag_q;
  assign target_code_o          = target_q;
  assign discharge_stop_level_o = (disch_stop_q <= pd_vbus_regs_pkg::DISCH_FLOOR_MAX)
                                  ? pd_vbus_regs_pkg::DISCH_FLOOR_LEVEL
                                  : (disch_stop_q & pd_vbus_regs_pkg::DISCH_IGNORE_MASK);
  assign cable_drop_gain_o      = gain_q;
  assign current_limit_target_o = ilim_q;
  assign converter_cfg_o        = conv_q;
  assign supervisor_timeout_o   = timeout_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  tx_clear_after_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_done_i |=> (tx_len_o == 5'h00) && !tx_req_o && (txb_state_q == pd_vbus_regs_pkg::TXB_AWAIT_COUNT))
    else $error("Transmit state not cleared after attempt.");
  tx_depth_bound_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_len_o <= 5'(TX_DEPTH))
    else $error("Transmit buffer grew past its depth.");
  tx_count_first_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (wr_txport && txb_state_q == pd_vbus_regs_pkg::TXB_AWAIT_COUNT && !tx_done_i && !xact_start_i)
    |=> $stable(tx_len_o) && (tx_remain_q == $past(reg_wdata_i)))
    else $error("Count byte was stored as payload.");
  volt_high_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == pd_vbus_regs_pkg::VOLT_MEAS_HIGH_OFS)
    |=> reg_rdata_o == {6'h00, $past(vbus_meas_q[9:8])})
    else $error("Voltage upper bits misplaced.");
  disch_floor_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    disch_stop_q <= pd_vbus_regs_pkg::DISCH_FLOOR_MAX |-> discharge_stop_level_o == pd_vbus_regs_pkg::DISCH_FLOOR_LEVEL)
    else $error("Discharge floor not applied.");
  disch_low_bits_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    discharge_stop_level_o[1:0] == 2'b00)
    else $error("Discharge threshold low bits not ignored.");
  over_reassert_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (over_cond_q && !volt_alarm_disable_n_i) |=> over_volt_flag_o)
    else $error("Over-voltage flag not set.");
  under_reassert_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (under_cond_q && !volt_alarm_disable_n_i) |=> under_volt_flag_o)
    else $error("Under-voltage flag not set.");
  alarm_disabled_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (!over_volt_flag_o && volt_alarm_disable_n_i) |=> !over_volt_flag_o)
    else $error("Over-voltage flag set while alarms disabled.");
  target_staged_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !apply_custom_voltage_cmd_i |=> $stable(target_code_o))
    else $error("Target moved without the apply command.");
  coarse_width_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (apply_custom_voltage_cmd_i && !fine_target_step_i) |=> target_code_o[10] == 1'b0)
    else $error("Coarse target wider than ten bits.");
  curr_top_zero_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == pd_vbus_regs_pkg::LOAD_CURR_MEAS_OFS) |=> reg_rdata_o[7] == 1'b0)
    else $error("Current register top bit set.");
  cond_update_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    volt_sample_i.valid |=> (over_cond_q == ($past(volt_sample_i.code) > $past(over_trip_q)))
                         && (under_cond_q == ($past(volt_sample_i.code) < $past(under_trip_q))))
    else $error("Alarm comparison not refreshed on conversion.");

endmodule

`default_nettype wire

// *** dv/vbus_adc_model.sv ***
/* ADC and PHY stand-in: one voltage sample per go pulse, one done pulse per request.
   Assumes the bench paces the go pulses. */
`default_nettype none
module vbus_adc_model (
  // Clock
  input  wire logic                      clk_sys_i,
  // Stimulus
  input  wire logic                      go_i,
  input  wire logic [9:0]                level_i,
  input  wire logic                      tx_req_i,
  // Answers
  output pd_vbus_regs_pkg::volt_sample_t smp_o,
  output logic                           done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  // The attempt takes a few cycles so the request is seen standing first.
  always_ff @(posedge clk_sys_i) begin
    smp_o  <= {go_i, level_i};
    cnt_q  <= tx_req_i ? cnt_q + 3'h1 : 3'h0;
    done_o <= cnt_q == 3'h3;
  end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
/* Bench for the power register bank.
   Assumes the ADC model answers every transmit request. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, xs, ts, go, cv, dis, oc, uc, fs, ap, tq, of, ov, uf, tr, dn;
  logic [7:0] a, d, q, rdd, il;
  logic [4:0] ri, ln;
  logic [9:0] lv, dl;
  logic [6:0] cc;
  logic [10:0] tc;
  logic [5:0] g;
  logic [1:0] st;
  pd_vbus_regs_pkg::converter_cfg_t cf;
  pd_vbus_regs_pkg::volt_sample_t smp;
  int err_count, comparisons;
  pd_vbus_regs DUT (.clk_sys_i(clk), .sys_rst_i(rst), .reg_addr_i(a), .reg_wr_i(wr), .reg_wdata_i(d),
    .reg_rd_i(rd), .xact_start_i(xs), .reg_rdata_o(q), .tx_start_i(ts), .tx_done_i(dn), .tx_rd_idx_i(ri),
    .tx_req_o(tq), .tx_len_o(ln), .tx_rd_data_o(rdd), .tx_overflow_o(of), .volt_sample_i(smp),
    .curr_valid_i(cv), .curr_code_i(cc), .volt_alarm_disable_n_i(dis), .over_flag_clr_i(oc),
    .under_flag_clr_i(uc), .over_volt_flag_o(ov), .under_volt_flag_o(uf), .fine_target_step_i(fs),
    .apply_custom_voltage_cmd_i(ap), .target_code_o(tc), .target_in_range_o(tr),
    .discharge_stop_level_o(dl), .cable_drop_gain_o(g), .current_limit_target_o(il),
    .converter_cfg_o(cf), .supervisor_timeout_o(st));
  vbus_adc_model pm (.clk_sys_i(clk), .go_i(go), .level_i(lv), .tx_req_i(tq), .smp_o(smp), .done_o(dn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tk(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pl(ref logic s);
    s = 1'b1;
    tk();
    s = 1'b0;
    tk();
  endtask
  task automatic wr_reg(logic [7:0] ad, logic [7:0] dt);
    a = ad;
    d = dt;
    pl(wr);
  endtask
  task automatic rd_reg(logic [7:0] ad, logic [7:0] e);
    a = ad;
    pl(rd);
    chk(16'(q), 16'(e));
  endtask
  task automatic sample(logic [9:0] v);
    lv = v;
    pl(go);
    tk(3);
  endtask
  task automatic tx_run();
    pl(ts);
    for (int i = 0; i < 20 && tq; i++) tk();
    chk(16'({of, tq, ln}), 16'h0);
  endtask
  task automatic final_report();
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {wr, rd, xs, ts, go, cv, dis, oc, uc, fs, ap, a, d, ri, lv, cc} = '0;
    rst = 1'b1;
    tk(10);
    rst = 1'b0;
    rd_reg(8'h74, 8'h20);
    rd_reg(8'h82, 8'h80);
    rd_reg(8'h83, 8'h74);
    rd_reg(8'h51, 8'h00);
    wr_reg(8'h74, 8'h18);
    chk(16'(dl), 16'h014);
    wr_reg(8'h74, 8'h23);
    wr_reg(8'h83, 8'hFF);
    wr_reg(8'h84, 8'h03);
    wr_reg(8'h81, 8'h3F);
    chk(16'({dl, st, g}), 16'h20FF);
    chk(16'(cf), 16'hFF);
    wr_reg(8'h82, 8'h28);
    chk(16'(il), 16'h28);
    wr_reg(8'h77, 8'h01);
    wr_reg(8'h78, 8'h50);
    sample(10'h101);
    chk(16'({ov, uf}), 16'h2);
    rd_reg(8'h71, 8'h01);
    rd_reg(8'h70, 8'h01);
    pl(oc);
    chk(16'(ov), 16'h1);
    sample(10'h04F);
    pl(oc);
    chk(16'({ov, uf}), 16'h1);
    pl(uc);
    chk(16'(uf), 16'h1);
    dis = 1'b1;
    pl(uc);
    chk(16'(uf), 16'h0);
    cc = 7'h7F;
    pl(cv);
    rd_reg(8'h80, 8'h7F);
    wr_reg(8'h7A, 8'hFF);
    wr_reg(8'h7B, 8'h07);
    fs = 1'b1;
    chk(16'(tc), 16'h0);
    pl(ap);
    chk(16'({tr, tc}), 16'hFFF);
    fs = 1'b0;
    pl(ap);
    chk(16'({tr, tc}), 16'hBFF);
    pl(xs);
    wr_reg(8'h51, 8'h02);
    wr_reg(8'h51, 8'hA5);
    wr_reg(8'h51, 8'h3C);
    wr_reg(8'h51, 8'h77);
    ri = 5'h1;
    tk();
    chk(16'({ln, rdd}), 16'h023C);
    tx_run();
    pl(xs);
    wr_reg(8'h51, 8'h1F);
    for (int i = 0; i < 31; i++) wr_reg(8'h51, 8'(i));
    chk(16'({of, ln}), 16'h3E);
    tx_run();
    final_report();
  end
endmodule
`default_nettype wire
